// file: logic/pio_host_consts.svh
// timing constants and field positions for the pio host controller
`ifndef PIO_HOST_CONSTS_SVH
`define PIO_HOST_CONSTS_SVH
`define CLK_PERIOD_PS 10000
`define T0_M0_NS 600
`define T0_M1_NS 383
`define T0_M2_NS 240
`define T0_M3_NS 180
`define T0_M4_NS 120
`define T0_M5_NS 100
`define T0_M6_NS 80
`define T2_M0_NS 165
`define T2_M1_NS 125
`define T2_M2_NS 100
`define T2_M3_NS 80
`define T2_M4_NS 70
`define T2_M5_NS 65
`define T2_M6_NS 55
`define T2_REG8_NS 290
`define IO_T2_NS 165
`define T2I_M3_NS 70
`define T2I_M4_NS 25
`define T2I_M5_NS 25
`define T2I_M6_NS 20
`define T1_M0_NS 70
`define T9_M0_NS 20
`define TA_NS 35
`define TB_NS 1250
`define WAIT_MAX_NS 350
`define IO_WAIT_MODE_FIRST 3'h7
`define MODE_WAIT_LAST 3'h4
`define MODE_REG8_LAST 3'h2
`define REQ_WIDTH 24
`define REQ_WR_BIT 23
`define REQ_REG_BIT 22
`define REQ_REG8_BIT 21
`define REQ_CEH_BIT 20
`define REQ_CEL_BIT 19
`define REQ_ADDR_MSB 18
`define REQ_ADDR_LSB 16
`define REQ_DATA_MSB 15
`define REQ_DATA_LSB 0
`define CNT_W 8
`define FIFO_DEPTH 8
`endif

// file: logic/pio_host_pkg.sv
// types shared by the pio host controller
package pio_host_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACTIVE, ST_RECOVER} phase_e;
  typedef logic [2:0] mode_t;
endpackage : pio_host_pkg

// file: logic/fifo_if.sv
// valid/ready carrier between the request fifo and the sequencer
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 23);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : fifo_if

// file: logic/req_fifo.sv
// small request fifo with registered read data
`timescale 1ns/1ps
module req_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  fifo_if.src out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic [AW:0] cnt;
  logic out_v_q;
  logic [WIDTH-1:0] out_q;
  logic push;
  logic pop;
  logic load;

  // ----------------------------------------
  // occupancy and handshakes
  // ----------------------------------------
  assign cnt = wr_q - rd_q;
  assign in_ready_o = (cnt != (AW+1)'(DEPTH));
  assign push = in_valid_i && in_ready_o;
  // output register refills when empty or being taken
  assign load = (cnt != '0) && (!out_v_q || out.ready);
  assign pop = load;
  assign out.valid = out_v_q;
  assign out.data = out_q;

  // storage array, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (ce_i && push)
      mem_q[wr_q[AW-1:0]] <= in_data_i;
  end

  // pointers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else if (ce_i)
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  // registered read data
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      out_v_q <= 1'b0;
      out_q <= '0;
    end
    else if (ce_i)
    begin
      if (load)
      begin
        out_v_q <= 1'b1;
        out_q <= mem_q[rd_q[AW-1:0]];
      end
      else if (out.ready)
        out_v_q <= 1'b0;
    end
  end
endmodule : req_fifo

// file: logic/pio_host.sv
// host-side sequencer for strobed pio read and write cycles
`timescale 1ns/1ps
module pio_host #(
  parameter int DW = 16,
  parameter int AW = 3
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  input wire pio_host_pkg::mode_t MODE_I,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic REQ_WRITE_I,
  input wire logic REQ_REG_I,
  input wire logic REQ_REG8_I,
  input wire logic [1:0] REQ_CE_I,
  input wire logic [AW-1:0] REQ_ADDR_I,
  input wire logic [DW-1:0] REQ_WDATA_I,
  output logic RD_VALID_O,
  output logic [DW-1:0] RD_DATA_O,
  output logic WAIT_TIMEOUT_O,
  output logic BUSY_O,
  output logic IO_READ_STROBE_N_O,
  output logic IO_WRITE_STROBE_N_O,
  output logic REGISTER_SPACE_SELECT_N_O,
  output logic CARD_ENABLE_LOW_N_O,
  output logic CARD_ENABLE_HIGH_N_O,
  output logic [AW-1:0] HOST_ADDRESS_BUS_O,
  input wire logic [DW-1:0] HOST_DATA_BUS_I,
  output logic [DW-1:0] HOST_DATA_BUS_O,
  output logic HOST_DATA_BUS_OE_N_O,
  input wire logic IORDY_I
);
  import pio_host_pkg::*;
`include "pio_host_consts.svh"

  // ----------------------------------------
  // time conversion
  // ----------------------------------------
  // least time, rounded up, at least one cycle
  function automatic logic [`CNT_W-1:0] ns_min(input int ns);
    int c;
    c = (ns * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
    if (c < 1)
      c = 1;
    return c[`CNT_W-1:0];
  endfunction : ns_min

  // longest time, rounded down, at least one cycle
  function automatic logic [`CNT_W-1:0] ns_max(input int ns);
    int c;
    c = (ns * 1000) / `CLK_PERIOD_PS;
    if (c < 1)
      c = 1;
    return c[`CNT_W-1:0];
  endfunction : ns_max

  // per-mode cycle time, active width and recovery
  function automatic logic [`CNT_W-1:0] t0_cyc(input mode_t m);
    unique case (m)
      3'h0: return ns_min(`T0_M0_NS);
      3'h1: return ns_min(`T0_M1_NS);
      3'h2: return ns_min(`T0_M2_NS);
      3'h3: return ns_min(`T0_M3_NS);
      3'h4: return ns_min(`T0_M4_NS);
      3'h5: return ns_min(`T0_M5_NS);
      default: return ns_min(`T0_M6_NS);
    endcase
  endfunction : t0_cyc

  function automatic logic [`CNT_W-1:0] t2_cyc(input mode_t m, input logic reg8);
    // 8-bit register strobes are stretched in the slow modes
    if (reg8 && m <= `MODE_REG8_LAST)
      return ns_min(`T2_REG8_NS);
    // card i/o takes the widest waited strobe so every i/o cycle mode is met
    if (m == `IO_WAIT_MODE_FIRST)
      return ns_min(`IO_T2_NS);
    unique case (m)
      3'h0: return ns_min(`T2_M0_NS);
      3'h1: return ns_min(`T2_M1_NS);
      3'h2: return ns_min(`T2_M2_NS);
      3'h3: return ns_min(`T2_M3_NS);
      3'h4: return ns_min(`T2_M4_NS);
      3'h5: return ns_min(`T2_M5_NS);
      default: return ns_min(`T2_M6_NS);
    endcase
  endfunction : t2_cyc

  function automatic logic [`CNT_W-1:0] t2i_cyc(input mode_t m);
    unique case (m)
      3'h3: return ns_min(`T2I_M3_NS);
      3'h4: return ns_min(`T2I_M4_NS);
      3'h5: return ns_min(`T2I_M5_NS);
      3'h6: return ns_min(`T2I_M6_NS);
      default: return ns_min(`T2I_M6_NS);
    endcase
  endfunction : t2i_cyc

  // ----------------------------------------
  // request buffer
  // ----------------------------------------
  fifo_if #(.W(`REQ_WIDTH)) req ();
  logic fifo_in_ready;
  logic [`REQ_WIDTH-1:0] req_word;

  // all three register address lines travel with the request
  assign req_word = {REQ_WRITE_I, REQ_REG_I, REQ_REG8_I, REQ_CE_I[1], REQ_CE_I[0],
                     REQ_ADDR_I, REQ_WDATA_I};

  req_fifo #(.WIDTH(`REQ_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .in_valid_i(REQ_VALID_I),
    .in_ready_o(fifo_in_ready),
    .in_data_i(req_word),
    .out(req)
  );

  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  phase_e phase_q;
  logic [`CNT_W-1:0] cnt_q;
  logic [`CNT_W-1:0] cyc_q;
  logic [`CNT_W-1:0] wait_q;
  logic [`REQ_WIDTH-1:0] cur_q;
  logic waiting;
  logic wait_allowed;
  logic wait_limit;
  logic active_done;
  logic take;

  // waits only exist in modes 0-4 and in card i/o mode 7
  assign wait_allowed = (MODE_I <= `MODE_WAIT_LAST) || (MODE_I == `IO_WAIT_MODE_FIRST);
  // longer limit in ide modes, shorter in card i/o mode
  assign wait_limit = (MODE_I == `IO_WAIT_MODE_FIRST) ? (wait_q >= ns_max(`WAIT_MAX_NS))
                                                      : (wait_q >= ns_max(`TB_NS));
  assign waiting = wait_allowed && (cnt_q >= ns_min(`TA_NS)) && !IORDY_I && !wait_limit;
  assign active_done = (cnt_q + 1'b1 >= t2_cyc(MODE_I, cur_q[`REQ_REG8_BIT])) && !waiting;
  assign take = (phase_q == ST_IDLE) && req.valid;
  assign req.ready = take;

  // phase and counters
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      phase_q <= ST_IDLE;
      cnt_q <= '0;
      cyc_q <= '0;
      cur_q <= '0;
    end
    else if (CE_I)
    begin
      unique case (phase_q)
        ST_IDLE:
          if (req.valid)
          begin
            cur_q <= req.data;
            phase_q <= ST_SETUP;
            cnt_q <= '0;
          end
        ST_SETUP:
          // address and enables settle before strobe
          if (cnt_q + 1'b1 >= ns_min(`T1_M0_NS))
          begin
            phase_q <= ST_ACTIVE;
            cnt_q <= '0;
            cyc_q <= '0;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        ST_ACTIVE:
          begin
            cyc_q <= cyc_q + 1'b1;
            if (active_done)
            begin
              phase_q <= ST_RECOVER;
              cnt_q <= '0;
            end
            else
              cnt_q <= cnt_q + 1'b1;
          end
        ST_RECOVER:
          begin
            cyc_q <= cyc_q + 1'b1;
            cnt_q <= cnt_q + 1'b1;
            // recovery stretched to reach the cycle time
            if ((cnt_q + 1'b1 >= t2i_cyc(MODE_I)) && (cnt_q + 1'b1 >= ns_min(`T9_M0_NS))
                && (cyc_q + 1'b1 >= t0_cyc(MODE_I)))
              phase_q <= ST_IDLE;
          end
      endcase
    end
  end

  // wait length counter and timeout flag
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      wait_q <= '0;
      WAIT_TIMEOUT_O <= 1'b0;
    end
    else if (CE_I)
    begin
      if (phase_q != ST_ACTIVE)
        wait_q <= '0;
      else if (wait_allowed && cnt_q >= ns_min(`TA_NS) && !IORDY_I)
        wait_q <= wait_q + 1'b1;
      // a stuck card cannot hang the port
      WAIT_TIMEOUT_O <= (phase_q == ST_ACTIVE) && wait_allowed && !IORDY_I && wait_limit;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // strobes and bus, all registered
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      IO_READ_STROBE_N_O <= 1'b1;
      IO_WRITE_STROBE_N_O <= 1'b1;
      REGISTER_SPACE_SELECT_N_O <= 1'b1;
      CARD_ENABLE_LOW_N_O <= 1'b1;
      CARD_ENABLE_HIGH_N_O <= 1'b1;
      HOST_ADDRESS_BUS_O <= '0;
      HOST_DATA_BUS_O <= '0;
      HOST_DATA_BUS_OE_N_O <= 1'b1;
      BUSY_O <= 1'b0;
      REQ_READY_O <= 1'b0;
    end
    else if (CE_I)
    begin
      REQ_READY_O <= fifo_in_ready;
      BUSY_O <= (phase_q != ST_IDLE) || req.valid;
      if (take)
      begin
        REGISTER_SPACE_SELECT_N_O <= !req.data[`REQ_REG_BIT];
        CARD_ENABLE_LOW_N_O <= !req.data[`REQ_CEL_BIT];
        CARD_ENABLE_HIGH_N_O <= !req.data[`REQ_CEH_BIT];
        HOST_ADDRESS_BUS_O <= AW'(req.data[`REQ_ADDR_MSB:`REQ_ADDR_LSB]);
        HOST_DATA_BUS_O <= req.data[`REQ_DATA_MSB:`REQ_DATA_LSB];
        HOST_DATA_BUS_OE_N_O <= !req.data[`REQ_WR_BIT];
      end
      if (phase_q == ST_SETUP && cnt_q + 1'b1 >= ns_min(`T1_M0_NS))
      begin
        IO_READ_STROBE_N_O <= cur_q[`REQ_WR_BIT];
        IO_WRITE_STROBE_N_O <= !cur_q[`REQ_WR_BIT];
      end
      if (phase_q == ST_ACTIVE && active_done)
      begin
        IO_READ_STROBE_N_O <= 1'b1;
        IO_WRITE_STROBE_N_O <= 1'b1;
      end
      // hold data and enables into the recovery, release them once T9_M0_NS has passed; address stays until the next request
      if (phase_q == ST_RECOVER && cnt_q + 1'b1 >= ns_min(`T9_M0_NS))
      begin
        HOST_DATA_BUS_OE_N_O <= 1'b1;
        CARD_ENABLE_LOW_N_O <= 1'b1;
        CARD_ENABLE_HIGH_N_O <= 1'b1;
        REGISTER_SPACE_SELECT_N_O <= 1'b1;
      end
    end
  end

  // read data captured at strobe end, after ready returned or the wait limit was hit
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      RD_VALID_O <= 1'b0;
      RD_DATA_O <= '0;
    end
    else if (CE_I)
    begin
      RD_VALID_O <= (phase_q == ST_ACTIVE) && active_done && !cur_q[`REQ_WR_BIT];
      if ((phase_q == ST_ACTIVE) && active_done && !cur_q[`REQ_WR_BIT])
        RD_DATA_O <= HOST_DATA_BUS_I;
    end
  end
endmodule : pio_host

// file: tb/pio_host_props.sv
// pin timing checks for the pio host controller
`timescale 1ns/1ps
module pio_host_props #(
  parameter int AW = 3
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire pio_host_pkg::mode_t MODE_I,
  input wire logic IORDY_I,
  input wire logic WAIT_TIMEOUT_O,
  input wire logic IO_READ_STROBE_N_O,
  input wire logic IO_WRITE_STROBE_N_O,
  input wire logic REGISTER_SPACE_SELECT_N_O,
  input wire logic CARD_ENABLE_LOW_N_O,
  input wire logic CARD_ENABLE_HIGH_N_O,
  input wire logic [AW-1:0] HOST_ADDRESS_BUS_O,
  input wire logic HOST_DATA_BUS_OE_N_O
);
  import pio_host_pkg::*;
  // ----
  // cycle counts at 10 ns, rounded up
  // ----
  localparam int T0C [8] = '{60, 39, 24, 18, 12, 10, 8, 0};
  localparam int T2C [8] = '{17, 13, 10, 8, 7, 7, 6, 17};
  localparam int REC [8] = '{0, 0, 0, 7, 3, 3, 2, 0};
  logic s;
  logic [7:0] act_q, idle_q, cyc_q;
  assign s = !(IO_READ_STROBE_N_O && IO_WRITE_STROBE_N_O);
  // saturating counters: strobe low, strobe high, edges since last strobe start
  always_ff @(posedge CLK_I or negedge RSTN_I)
    if (!RSTN_I) act_q <= 8'h00;
    else act_q <= s ? act_q + {7'h00, act_q != 8'hff} : 8'h00;
  always_ff @(posedge CLK_I or negedge RSTN_I)
    if (!RSTN_I) idle_q <= 8'hff;
    else idle_q <= s ? 8'h00 : idle_q + {7'h00, idle_q != 8'hff};
  // restarts at the edge where the strobe is first seen low
  always_ff @(posedge CLK_I or negedge RSTN_I)
    if (!RSTN_I) cyc_q <= 8'hff;
    else cyc_q <= (s && act_q == 8'h00) ? 8'h01 : cyc_q + {7'h00, cyc_q != 8'hff};
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence strobe_on;
    $rose(s);
  endsequence
  sequence strobe_off;
    $fell(s);
  endsequence
  AST_CYCLE_MIN: assert property (strobe_on |-> cyc_q >= T0C[MODE_I])
    else $error("strobes closer than cycle time");
  AST_ACTIVE_MIN: assert property (strobe_off |-> act_q >= T2C[MODE_I])
    else $error("strobe too short");
  AST_RECOVERY: assert property (strobe_on |-> idle_q >= REC[MODE_I])
    else $error("recovery too short");
  AST_WAIT_HOLD: assert property (s && !IORDY_I && !$past(IORDY_I) && MODE_I < 3'h5
    && act_q > 8'd4 && act_q < 8'd120 |=> s || WAIT_TIMEOUT_O)
    else $error("strobe ended during wait");
  AST_WAIT_END: assert property (s && $rose(IORDY_I) && act_q > 8'd20 |-> ##[1:4] !s)
    else $error("strobe not ended after wait");
  AST_SELECT_HELD: assert property (s && $past(s) |-> $stable({HOST_ADDRESS_BUS_O,
    CARD_ENABLE_LOW_N_O, CARD_ENABLE_HIGH_N_O, REGISTER_SPACE_SELECT_N_O}))
    else $error("select moved under strobe");
  AST_CARD_ENABLED: assert property (s |-> !(CARD_ENABLE_LOW_N_O && CARD_ENABLE_HIGH_N_O))
    else $error("strobe without card enable");
  AST_DATA_DIR: assert property (s |-> HOST_DATA_BUS_OE_N_O == IO_WRITE_STROBE_N_O)
    else $error("data direction wrong");
endmodule : pio_host_props

bind pio_host pio_host_props #(.AW(AW)) u_props (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .MODE_I(MODE_I),
  .IORDY_I(IORDY_I), .WAIT_TIMEOUT_O(WAIT_TIMEOUT_O), .IO_READ_STROBE_N_O(IO_READ_STROBE_N_O),
  .IO_WRITE_STROBE_N_O(IO_WRITE_STROBE_N_O), .REGISTER_SPACE_SELECT_N_O(REGISTER_SPACE_SELECT_N_O),
  .CARD_ENABLE_LOW_N_O(CARD_ENABLE_LOW_N_O), .CARD_ENABLE_HIGH_N_O(CARD_ENABLE_HIGH_N_O),
  .HOST_ADDRESS_BUS_O(HOST_ADDRESS_BUS_O), .HOST_DATA_BUS_OE_N_O(HOST_DATA_BUS_OE_N_O));

// file: tb/card_model.sv
// behavioural card on the far side of the pio pins
`timescale 1ns/1ps
module card_model (
  input wire logic clk_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wd_i,
  input wire logic [2:0] mode_i,
  input wire logic [7:0] wait_i,
  output logic [15:0] rd_o,
  output logic rdy_o
);
  logic [15:0] mem_q [8];
  logic wr_n_q = 1'b1;
  logic rdy;
  int n = 0;
  initial
  begin
    rd_o = 16'h5a5a;
    rdy_o = 1'b1;
  end
  // no 16-bit indication pin: this host runs every data access 16 bits wide
  // wait length set by the bench, none in modes 5 and 6, low one clock after strobe
  assign rdy = !(!(rd_n_i && wr_n_i) && (mode_i < 3'h5 || mode_i == 3'h7) && n < wait_i);
  // ----
  // pin behaviour
  // ----
  always @(posedge clk_i)
  begin
    n <= (rd_n_i && wr_n_i) ? 0 : n + 1;
    rdy_o <= rdy;
    wr_n_q <= wr_n_i;
    // data valid with ready; a released bus flips so stale data never matches
    rd_o <= (!rd_n_i && rdy) ? mem_q[addr_i] : ~rd_o;
    if (wr_n_i && !wr_n_q) mem_q[addr_i] <= wd_i;
  end
endmodule : card_model

// file: tb/tb_pio_host.sv
// self-checking bench for the pio host controller
`timescale 1ns/1ps
module tb_pio_host;
  import pio_host_pkg::*;
  logic CLK_I = 1'b0;
  logic RSTN_I, CE_I, REQ_VALID_I, REQ_READY_O, REQ_WRITE_I, REQ_REG_I, REQ_REG8_I, IORDY_I;
  logic RD_VALID_O, WAIT_TIMEOUT_O, BUSY_O, IO_READ_STROBE_N_O, IO_WRITE_STROBE_N_O;
  logic REGISTER_SPACE_SELECT_N_O, CARD_ENABLE_LOW_N_O, CARD_ENABLE_HIGH_N_O, HOST_DATA_BUS_OE_N_O;
  mode_t MODE_I;
  logic [1:0] REQ_CE_I;
  logic [2:0] REQ_ADDR_I, HOST_ADDRESS_BUS_O;
  logic [15:0] REQ_WDATA_I, RD_DATA_O, HOST_DATA_BUS_I, HOST_DATA_BUS_O;
  logic [7:0] wait_c;
  logic [15:0] mem [8];
  logic [15:0] exp_q [$];
  logic [5:0] sel_q [$];
  logic [5:0] sel_now;
  int mismatches, n_checks, cur_w, last_w;
  bit to_seen, full_seen;
  // timeout table: mode, wait cycles, expected flag
  mode_t tm [4] = '{3'h0, 3'h2, 3'h7, 3'h7};
  logic [7:0] tw [4] = '{8'd200, 8'd100, 8'd50, 8'd20};
  bit te [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  always #5 CLK_I = ~CLK_I;
  pio_host dut (.CLK_I, .RSTN_I, .CE_I, .MODE_I, .REQ_VALID_I, .REQ_READY_O, .REQ_WRITE_I, .REQ_REG_I,
    .REQ_REG8_I, .REQ_CE_I, .REQ_ADDR_I, .REQ_WDATA_I, .RD_VALID_O, .RD_DATA_O, .WAIT_TIMEOUT_O,
    .BUSY_O, .IO_READ_STROBE_N_O, .IO_WRITE_STROBE_N_O, .REGISTER_SPACE_SELECT_N_O,
    .CARD_ENABLE_LOW_N_O, .CARD_ENABLE_HIGH_N_O, .HOST_ADDRESS_BUS_O, .HOST_DATA_BUS_I,
    .HOST_DATA_BUS_O, .HOST_DATA_BUS_OE_N_O, .IORDY_I);
  card_model card (.clk_i(CLK_I), .rd_n_i(IO_READ_STROBE_N_O), .wr_n_i(IO_WRITE_STROBE_N_O),
    .addr_i(HOST_ADDRESS_BUS_O), .wd_i(HOST_DATA_BUS_O), .mode_i(MODE_I), .wait_i(wait_c),
    .rd_o(HOST_DATA_BUS_I), .rdy_o(IORDY_I));
  assign sel_now = {REGISTER_SPACE_SELECT_N_O, CARD_ENABLE_HIGH_N_O, CARD_ENABLE_LOW_N_O, HOST_ADDRESS_BUS_O};
  // ----
  // tasks
  // ----
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok)
    begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  // valid rises only while the fifo shows room and drops for a cycle, as ready lags
  task automatic req(input logic w, input logic [2:0] a, input logic r8);
    logic [15:0] d;
    d = 16'($urandom);
    @(negedge CLK_I);
    {REQ_WRITE_I, REQ_ADDR_I, REQ_REG8_I, REQ_WDATA_I} = {w, a, r8, d};
    REQ_REG_I = 1'($urandom);
    REQ_CE_I = 2'($urandom_range(3, 1));
    while (REQ_READY_O !== 1'b1)
    begin
      full_seen = 1'b1;
      @(negedge CLK_I);
    end
    REQ_VALID_I = 1'b1;
    @(negedge CLK_I);
    REQ_VALID_I = 1'b0;
    if (w) mem[a] = d;
    else exp_q.push_back(mem[a]);
    sel_q.push_back({!REQ_REG_I, !REQ_CE_I[1], !REQ_CE_I[0], a});
  endtask : req
  // idle means busy low for 64 edges, longer than any cycle time
  task automatic drain;
    int k;
    k = 0;
    while (k < 64)
    begin
      @(negedge CLK_I);
      k = (BUSY_O === 1'b0) ? k + 1 : 0;
    end
  endtask : drain
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // read results against the oldest note
  always @(negedge CLK_I)
    if (RD_VALID_O === 1'b1) chk(exp_q.size() != 0 && RD_DATA_O === exp_q.pop_front(), "read data");
  // strobe width and timeout flag
  always @(negedge CLK_I)
  begin
    if (WAIT_TIMEOUT_O === 1'b1) to_seen = 1'b1;
    if (IO_READ_STROBE_N_O === 1'b0 || IO_WRITE_STROBE_N_O === 1'b0)
    begin
      // select and address noted at request time, compared as the strobe first shows
      if (cur_w == 0) chk(sel_q.size() != 0 && sel_now === sel_q.pop_front(), "select");
      cur_w++;
    end
    else if (cur_w != 0)
    begin
      last_w = cur_w;
      cur_w = 0;
    end
  end
  initial
  begin
    repeat (60000) @(posedge CLK_I);
    mismatches++;
    close_out;
  end
  initial
  begin
    {RSTN_I, CE_I, REQ_VALID_I, REQ_WRITE_I, REQ_REG_I, REQ_REG8_I} = 6'h10;
    {MODE_I, REQ_CE_I, REQ_ADDR_I, REQ_WDATA_I, wait_c} = 32'h0;
    void'($urandom(58));
    repeat (6) @(negedge CLK_I);
    chk({IO_READ_STROBE_N_O, IO_WRITE_STROBE_N_O, HOST_DATA_BUS_OE_N_O, RD_VALID_O} === 4'he, "reset");
    RSTN_I = 1'b1;
    // every mode: write, read back, then an 8-bit register read, queued back to back
    for (int m = 0; m < 8; m++)
    begin
      MODE_I = 3'(m);
      wait_c = 8'(m % 2 * 30);
      req(1'b1, 3'(m), 1'b0);
      req(1'b0, 3'(m), 1'b0);
      req(1'b0, 3'(m), 1'b1);
      drain;
      if (m < 3) chk(last_w >= 29, "register strobe width");
    end
    // waits either side of each limit
    foreach (tm[i])
    begin
      MODE_I = tm[i];
      wait_c = tw[i];
      to_seen = 1'b0;
      req(1'b1, 3'h1, 1'b0);
      drain;
      chk(to_seen === te[i], "wait limit");
    end
    // freeze mid cycle, then fill the fifo until it refuses
    {MODE_I, wait_c, full_seen} = 12'h0;
    fork
      req(1'b1, 3'h2, 1'b0);
      begin
        repeat (20) @(negedge CLK_I);
        CE_I = 1'b0;
        repeat (5) @(negedge CLK_I);
        CE_I = 1'b1;
      end
    join
    repeat (12) req(1'($urandom), 3'($urandom), 1'($urandom));
    chk(full_seen, "fifo never full");
    drain;
    chk(exp_q.size() == 0 && sel_q.size() == 0, "cycles missing");
    close_out;
  end
endmodule : tb_pio_host
